//--- hw/ser_pkg.sv
package ser_pkg;

  localparam int          BYTE_W           = 8;
  localparam int          CLOCK_HZ         = 100_000_000;
  localparam int          VERIFY_TIMEOUT_S = 5;
  localparam int          VERIFY_CYCLES    = VERIFY_TIMEOUT_S * CLOCK_HZ;

  localparam logic [7:0]  ESR_RESET        = 8'h80;
  localparam logic [7:0]  ESR_USED_MASK    = 8'hBD;
  localparam logic [7:0]  STB_USED_MASK    = 8'h77;
  localparam int          ESR_OPC          = 0;
  localparam int          ESR_QUERY        = 2;
  localparam int          ESR_VERIFY       = 3;
  localparam int          ESR_EXEC         = 4;
  localparam int          ESR_CMD          = 5;
  localparam int          ESR_PON          = 7;
  localparam int          STB_LIM_LSB      = 0;
  localparam int          STB_MAV          = 4;
  localparam int          STB_ESB          = 5;
  localparam int          STB_MSS          = 6;
  localparam int          LIMIT_OUTPUTS    = 3;

  localparam logic [7:0]  EXEC_NONE        = 8'h00;
  localparam logic [7:0]  EXEC_RECALL      = 8'h66;
  localparam logic [7:0]  EXEC_INVALID     = 8'h67;
  localparam logic [7:0]  EXEC_DENIED      = 8'hC8;
  localparam logic [7:0]  QERR_INTERRUPTED = 8'h01;
  localparam logic [7:0]  QERR_DEADLOCK    = 8'h02;
  localparam logic [7:0]  QERR_UNTERM      = 8'h03;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;

  localparam int          PP_LINE_W        = 3;
  localparam int          PP_SENSE_BIT     = 3;

  typedef enum logic [3:0] {
    SER_CMD_NONE,
    SER_CMD_SET_ESE,
    SER_CMD_SET_SRE,
    SER_CMD_SET_PRE,
    SER_CMD_GET_ESR,
    SER_CMD_GET_ESE,
    SER_CMD_GET_EER,
    SER_CMD_GET_QER,
    SER_CMD_GET_STB,
    SER_CMD_GET_SRE,
    SER_CMD_GET_PRE,
    SER_CMD_GET_IST,
    SER_CMD_CLS,
    SER_CMD_OPC,
    SER_CMD_PP_CONFIG,
    SER_CMD_PP_RELEASE
  } ser_cmd_code_t;

  typedef struct packed {
    logic          valid;
    ser_cmd_code_t code;
    logic [7:0]    data;
  } ser_cmd_t;

  typedef struct packed {
    logic       syntax_err;
    logic       exec_err;
    logic [7:0] exec_code;
    logic       priv_denied;
    logic       verify_start;
    logic       verify_done;
    logic       msg_ready;
    logic       term_sent;
    logic       talk_addr;
    logic       formatter_idle;
    logic       queue_empty;
    logic       queue_full;
    logic       term_parsed;
    logic       second_end;
    logic       serial_poll;
    logic       pp_active;
  } ser_event_t;

endpackage : ser_pkg

//--- hw/ser_status_core.sv
`timescale 1ns/1ps
// Contract
// - Power-up loads event_status with 128: power-on bit set, rest clear.
// - event_status bits 6,1 and status_summary bits 7,3 always read zero.
// - Syntax error sets event_status bit 5 and resets the parser.
// - Non-zero execution code written sets event_status bit 4.
// - Verify target not reached within 5 s sets event_status bit 3.
// - event_status bit 0 is set only by the operation-complete command.
// - Reading event_status returns it and clears it.
// - Summary bit 5 set when event_status and event_enable share a one.
// - exec_error_code holds last error: 0 none, 102 recall, 103 invalid.
// - Unprivileged state change sets bit 4 and loads 200.
// - exec_error_code clears on read and is zero at power-up.
// - exec_error_code has no mask; any error always sets bit 4.
// - Summary bit 6 set when any summary bit meets a set request-mask bit.
// - Bit 6 gives MSS on query, RQS on serial poll; RQS clears when polled.
// - Message-available set when response ready, cleared after terminator sent.
// - Summary bits 2,1,0 follow limit summaries of outputs 3,2,1.
// - ist is one exactly when summary and poll mask share a one; readable.
// - Poll line and sense set by config, released by release; drives low only.
// - Talk with idle formatter and empty queue: bit 2, code 3, parser reset.
// - Queue full with pending response: bit 2, code 2, discard response.
// - Terminator or second END with pending response: bit 2, code 1, discard.
// - Error codes and event_status clear on read and on clear-status.
// - Each interface instance keeps its own independent copy of these registers.
module ser_status_core #(
  parameter int VERIFY_CYCLES = ser_pkg::VERIFY_CYCLES
) (
  input  wire logic               CLOCK_I,
  input  wire logic               RST_I,
  input  wire ser_pkg::ser_cmd_t   CMD_I,
  input  wire ser_pkg::ser_event_t EVENT_I,
  input  wire logic [2:0]         LIMIT_SUM_I,
  output logic                    RESP_VALID_O,
  output logic [7:0]              RESP_DATA_O,
  output logic                    PARSER_RESET_O,
  output logic                    DISCARD_RESP_O,
  output logic                    SRQ_O,
  output logic                    IST_O,
  output logic [7:0]              DIO_O,
  output logic [7:0]              DIO_OE_O
);

  // Refuse a verify window the counter cannot time
  if (VERIFY_CYCLES < 1) begin : g_bad_cycles
    $error("VERIFY_CYCLES must be at least one");
  end

  function automatic logic mask_any(input logic [7:0] a, input logic [7:0] b);
    mask_any = |(a & b);
  endfunction : mask_any

  localparam int CNT_W = $clog2(VERIFY_CYCLES + 1);

  // Per-instance state; each interface gets its own copy of this module
  logic [7:0]       event_status;
  logic [7:0]       event_enable;
  logic [7:0]       exec_error_code;
  logic [7:0]       query_error_code;
  logic [7:0]       service_request_mask;
  logic [7:0]       parallel_poll_mask;
  logic             mav;
  logic             rqs;
  logic             mss_prev;
  logic             verify_busy;
  logic [CNT_W-1:0] verify_cnt;
  logic             pp_enabled;
  logic [3:0]       pp_cfg;

  wire ser_pkg::ser_event_t ev = EVENT_I;
  wire ser_pkg::ser_cmd_t   cmd = CMD_I;

  function automatic logic is_cmd(input ser_pkg::ser_cmd_t c, input ser_pkg::ser_cmd_code_t k);
    is_cmd = c.valid && (c.code == k);
  endfunction : is_cmd

  // Query error detection, priority unterminated > deadlock > interrupted
  wire q_unterm  = ev.talk_addr && ev.formatter_idle && ev.queue_empty;
  wire q_dead    = mav && ev.queue_full;
  wire q_intr    = mav && (ev.term_parsed || ev.second_end);
  wire q_any     = q_unterm || q_dead || q_intr;
  wire [7:0] q_code = q_unterm ? ser_pkg::QERR_UNTERM :
                      q_dead   ? ser_pkg::QERR_DEADLOCK : ser_pkg::QERR_INTERRUPTED;
  wire discard   = (q_dead || q_intr) && !q_unterm;

  // Execution error code source
  wire       e_set  = ev.priv_denied || (ev.exec_err && ev.exec_code != ser_pkg::EXEC_NONE);
  wire [7:0] e_code = ev.priv_denied ? ser_pkg::EXEC_DENIED : ev.exec_code;

  wire verify_timeout = verify_busy && (verify_cnt == CNT_W'(VERIFY_CYCLES - 1));

  wire cls     = is_cmd(cmd, ser_pkg::SER_CMD_CLS);
  wire rd_esr  = is_cmd(cmd, ser_pkg::SER_CMD_GET_ESR);
  wire rd_eer  = is_cmd(cmd, ser_pkg::SER_CMD_GET_EER);
  wire rd_qer  = is_cmd(cmd, ser_pkg::SER_CMD_GET_QER);

  logic [7:0] esr_set;
  always_comb begin
    esr_set                      = ser_pkg::ZERO_BYTE;
    esr_set[ser_pkg::ESR_CMD]    = ev.syntax_err;
    esr_set[ser_pkg::ESR_EXEC]   = e_set;
    esr_set[ser_pkg::ESR_VERIFY] = verify_timeout;
    esr_set[ser_pkg::ESR_QUERY]  = q_any;
    esr_set[ser_pkg::ESR_OPC]    = is_cmd(cmd, ser_pkg::SER_CMD_OPC);
  end

  // Clear on read or clear-status; a same-cycle event survives
  wire [7:0] next_event_status = (((rd_esr || cls) ? ser_pkg::ZERO_BYTE : event_status)
                                  | esr_set) & ser_pkg::ESR_USED_MASK;
  wire [7:0] next_exec_error   = e_set ? e_code :
                                 ((rd_eer || cls) ? ser_pkg::ZERO_BYTE : exec_error_code);
  wire [7:0] next_query_error  = q_any ? q_code :
                                 ((rd_qer || cls) ? ser_pkg::ZERO_BYTE : query_error_code);

  // Status summary assembly
  wire       esb      = mask_any(event_status, event_enable);
  logic [7:0] stb_base;
  always_comb begin
    stb_base = ser_pkg::ZERO_BYTE;
    stb_base[ser_pkg::STB_LIM_LSB +: ser_pkg::LIMIT_OUTPUTS] = LIMIT_SUM_I;
    stb_base[ser_pkg::STB_MAV] = mav;
    stb_base[ser_pkg::STB_ESB] = esb;
  end
  wire        mss      = mask_any(stb_base, service_request_mask);
  wire [7:0]  stb_mss  = (stb_base | (8'(mss) << ser_pkg::STB_MSS)) & ser_pkg::STB_USED_MASK;
  wire [7:0]  stb_rqs  = (stb_base | (8'(rqs) << ser_pkg::STB_MSS)) & ser_pkg::STB_USED_MASK;
  wire        ist      = mask_any(stb_mss, parallel_poll_mask);

  logic [7:0] resp_mux;
  always_comb begin
    case (cmd.code)
      ser_pkg::SER_CMD_GET_ESR: resp_mux = event_status;
      ser_pkg::SER_CMD_GET_ESE: resp_mux = event_enable;
      ser_pkg::SER_CMD_GET_EER: resp_mux = exec_error_code;
      ser_pkg::SER_CMD_GET_QER: resp_mux = query_error_code;
      ser_pkg::SER_CMD_GET_STB: resp_mux = stb_mss;
      ser_pkg::SER_CMD_GET_SRE: resp_mux = service_request_mask;
      ser_pkg::SER_CMD_GET_PRE: resp_mux = parallel_poll_mask;
      ser_pkg::SER_CMD_GET_IST: resp_mux = 8'(ist);
      default:                  resp_mux = ser_pkg::ZERO_BYTE;
    endcase
  end
  wire is_query = cmd.valid && (cmd.code >= ser_pkg::SER_CMD_GET_ESR)
                  && (cmd.code <= ser_pkg::SER_CMD_GET_IST);

  // Parallel poll drive: line pulled low only, released otherwise
  wire [7:0] pp_line = 8'h01 << pp_cfg[ser_pkg::PP_LINE_W-1:0];
  wire       pp_hit  = pp_enabled && ev.pp_active && (ist == pp_cfg[ser_pkg::PP_SENSE_BIT]);
  wire [7:0] next_dio_oe = pp_hit ? pp_line : ser_pkg::ZERO_BYTE;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      event_status     <= ser_pkg::ESR_RESET;
      exec_error_code  <= ser_pkg::ZERO_BYTE;
      query_error_code <= ser_pkg::ZERO_BYTE;
    end else begin
      event_status     <= next_event_status;
      exec_error_code  <= next_exec_error;
      query_error_code <= next_query_error;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      event_enable         <= ser_pkg::ZERO_BYTE;
      service_request_mask <= ser_pkg::ZERO_BYTE;
      parallel_poll_mask   <= ser_pkg::ZERO_BYTE;
    end else begin
      if (is_cmd(cmd, ser_pkg::SER_CMD_SET_ESE)) begin
        event_enable <= cmd.data;
      end
      if (is_cmd(cmd, ser_pkg::SER_CMD_SET_SRE)) begin
        service_request_mask <= cmd.data;
      end
      if (is_cmd(cmd, ser_pkg::SER_CMD_SET_PRE)) begin
        parallel_poll_mask <= cmd.data;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mav <= 1'b0;
    end else if (ev.msg_ready) begin
      mav <= 1'b1;
    end else if (ev.term_sent || discard) begin
      mav <= 1'b0;
    end
  end

  // RQS latches on a new MSS edge, clears when polled; a new edge wins
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rqs      <= 1'b0;
      mss_prev <= 1'b0;
    end else begin
      mss_prev <= mss;
      if (mss && !mss_prev) begin
        rqs <= 1'b1;
      end else if (ev.serial_poll || !mss) begin
        rqs <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      verify_busy <= 1'b0;
      verify_cnt  <= '0;
    end else if (ev.verify_start) begin
      verify_busy <= 1'b1;
      verify_cnt  <= '0;
    end else if (ev.verify_done || verify_timeout) begin
      verify_busy <= 1'b0;
    end else if (verify_busy) begin
      verify_cnt  <= verify_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pp_enabled <= 1'b0;
      pp_cfg     <= 4'h0;
    end else if (is_cmd(cmd, ser_pkg::SER_CMD_PP_CONFIG)) begin
      pp_enabled <= 1'b1;
      pp_cfg     <= cmd.data[3:0];
    end else if (is_cmd(cmd, ser_pkg::SER_CMD_PP_RELEASE)) begin
      pp_enabled <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      RESP_VALID_O   <= 1'b0;
      RESP_DATA_O    <= ser_pkg::ZERO_BYTE;
      PARSER_RESET_O <= 1'b0;
      DISCARD_RESP_O <= 1'b0;
      SRQ_O          <= 1'b0;
      IST_O          <= 1'b0;
      DIO_O          <= ser_pkg::ZERO_BYTE;
      DIO_OE_O       <= ser_pkg::ZERO_BYTE;
    end else begin
      RESP_VALID_O   <= is_query || ev.serial_poll;
      RESP_DATA_O    <= ev.serial_poll ? stb_rqs : resp_mux;
      PARSER_RESET_O <= ev.syntax_err || q_unterm;
      DISCARD_RESP_O <= discard;
      SRQ_O          <= rqs;
      IST_O          <= ist;
      DIO_O          <= ser_pkg::ZERO_BYTE;
      DIO_OE_O       <= next_dio_oe;
    end
  end

  sequence s_query_error;
    ev.talk_addr && ev.formatter_idle && ev.queue_empty;
  endsequence
  sequence s_qer_three;
    query_error_code == ser_pkg::QERR_UNTERM && event_status[ser_pkg::ESR_QUERY];
  endsequence

  chk_reset_pon: assert property (@(posedge CLOCK_I) $past(RST_I) && !RST_I |->
    event_status == ser_pkg::ESR_RESET) else $error("event status not 128 after reset");
  chk_unused_zero: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (event_status & ~ser_pkg::ESR_USED_MASK) == 8'h00 && (stb_mss & 8'h88) == 8'h00)
    else $error("unused status bit set");
  chk_syntax_bit: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ev.syntax_err |=> event_status[ser_pkg::ESR_CMD] && PARSER_RESET_O)
    else $error("syntax error not reported");
  chk_opc_only: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !event_status[ser_pkg::ESR_OPC] ##1 event_status[ser_pkg::ESR_OPC]
    |-> $past(cmd.valid) && $past(cmd.code) == ser_pkg::SER_CMD_OPC)
    else $error("opc bit set without command");
  chk_esr_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    rd_esr && esr_set == 8'h00 |-> ##1 event_status == 8'h00 && RESP_VALID_O)
    else $error("event status not cleared by read");
  chk_denied_code: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ev.priv_denied |=> exec_error_code == ser_pkg::EXEC_DENIED
    && event_status[ser_pkg::ESR_EXEC]) else $error("access denied not logged");
  chk_esb_mask: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    is_cmd(cmd, ser_pkg::SER_CMD_GET_STB) && !ev.serial_poll
    |=> RESP_DATA_O[ser_pkg::STB_ESB] == $past(|(event_status & event_enable)))
    else $error("esb mismatch");
  chk_unterm_seq: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_query_error |=> s_qer_three) else $error("unterminated error not logged");
  chk_mav_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    mav && ev.term_sent && !ev.msg_ready |=> !mav) else $error("mav not cleared");
  chk_ist_out: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    ##1 IST_O == $past(|(stb_mss & parallel_poll_mask))) else $error("ist wrong");
  chk_pp_release: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    is_cmd(cmd, ser_pkg::SER_CMD_PP_RELEASE) |-> ##2 DIO_OE_O == 8'h00)
    else $error("poll line not released");

endmodule : ser_status_core

//--- testbench/ser_ctrl_model.sv
`timescale 1ns/1ps
module ser_ctrl_model (
  input  wire logic                clk_i,
  input  wire logic [7:0]          dio_oe_i,
  output ser_pkg::ser_cmd_t        cmd_o,
  output ser_pkg::ser_event_t      ev_o,
  output logic [7:0]               dio_bus_o
);
  ser_pkg::ser_event_t lvl;
  ser_pkg::ser_event_t pls;

  assign ev_o = lvl | pls;
  // Passive pull-up: a line reads low only while the device asserts it
  assign dio_bus_o = ~dio_oe_i;

  initial begin
    cmd_o = '0;
    lvl = '0;
    pls = '0;
  end

  // One command, held across exactly one taking edge
  task automatic send(input ser_pkg::ser_cmd_code_t c, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    cmd_o = '{valid: 1'b1, code: c, data: d};
    @(posedge clk_i);
    #1;
    cmd_o = '0;
  endtask : send

  // One-cycle event pulse
  task automatic pulse(input ser_pkg::ser_event_t e);
    @(posedge clk_i);
    #1;
    pls = e;
    @(posedge clk_i);
    #1;
    pls = '0;
  endtask : pulse

  task automatic set_pp(input logic on);
    @(posedge clk_i);
    #1;
    lvl.pp_active = on;
  endtask : set_pp
endmodule : ser_ctrl_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int VC = 20;
  localparam ser_pkg::ser_event_t talk_idle = '{talk_addr: 1'b1, formatter_idle: 1'b1,
                                                queue_empty: 1'b1, default: '0};
  logic                clk;
  logic                rst;
  logic [2:0]          lim;
  ser_pkg::ser_cmd_t   cmd;
  ser_pkg::ser_event_t ev;
  logic                resp_v;
  logic [7:0]          resp_d;
  logic                prst;
  logic                disc;
  logic                srq;
  logic                ist;
  logic [7:0]          dio;
  logic [7:0]          dio_oe;
  logic [7:0]          bus;
  int                  n_mismatch;
  int                  total_checks;
  logic [7:0]          codes [2] = '{8'h66, 8'h67};
  ser_pkg::ser_cmd_code_t zq [7] = '{ser_pkg::SER_CMD_GET_ESE, ser_pkg::SER_CMD_GET_EER,
    ser_pkg::SER_CMD_GET_QER, ser_pkg::SER_CMD_GET_STB, ser_pkg::SER_CMD_GET_SRE,
    ser_pkg::SER_CMD_GET_PRE, ser_pkg::SER_CMD_GET_IST};

  ser_status_core #(.VERIFY_CYCLES(VC)) DUT (
    .CLOCK_I(clk), .RST_I(rst), .CMD_I(cmd), .EVENT_I(ev), .LIMIT_SUM_I(lim),
    .RESP_VALID_O(resp_v), .RESP_DATA_O(resp_d), .PARSER_RESET_O(prst),
    .DISCARD_RESP_O(disc), .SRQ_O(srq), .IST_O(ist), .DIO_O(dio), .DIO_OE_O(dio_oe)
  );

  ser_ctrl_model u_ctrl (
    .clk_i(clk), .dio_oe_i(dio_oe), .cmd_o(cmd), .ev_o(ev), .dio_bus_o(bus)
  );

  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits a bounded time for the answer pulse, then compares its byte
  task automatic answer(input logic [7:0] exp);
    int n;
    for (n = 0; n < 4 && resp_v !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 4) begin
      n_mismatch++;
      results();
    end else begin
      chk(resp_d, exp);
    end
  endtask : answer

  // Lets n edges pass, then steps off the edge before anything is looked at
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic query(input ser_pkg::ser_cmd_code_t c, input logic [7:0] exp);
    u_ctrl.send(c, 8'h00);
    answer(exp);
  endtask : query

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    lim = 3'h0;
    n_mismatch = 0;
    total_checks = 0;
    idle(8);
    rst = 1'b0;
    query(ser_pkg::SER_CMD_GET_ESR, 8'h80);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h00);
    foreach (zq[i]) query(zq[i], 8'h00);
    u_ctrl.send(ser_pkg::SER_CMD_SET_ESE, 8'hFF);
    query(ser_pkg::SER_CMD_GET_ESE, 8'hFF);
    u_ctrl.send(ser_pkg::SER_CMD_OPC, 8'h00);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h01);
    u_ctrl.pulse('{syntax_err: 1'b1, default: '0});
    chk({7'h00, prst}, 8'h01);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h20);
    foreach (codes[i]) begin
      u_ctrl.pulse('{exec_err: 1'b1, exec_code: codes[i], default: '0});
      query(ser_pkg::SER_CMD_GET_EER, codes[i]);
    end
    query(ser_pkg::SER_CMD_GET_EER, 8'h00);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h10);
    u_ctrl.pulse('{exec_err: 1'b1, exec_code: 8'h00, default: '0});
    query(ser_pkg::SER_CMD_GET_ESR, 8'h00);
    query(ser_pkg::SER_CMD_GET_EER, 8'h00);
    u_ctrl.send(ser_pkg::SER_CMD_SET_ESE, 8'h10);
    u_ctrl.pulse('{priv_denied: 1'b1, exec_err: 1'b1, exec_code: 8'h66, default: '0});
    query(ser_pkg::SER_CMD_GET_STB, 8'h20);
    u_ctrl.send(ser_pkg::SER_CMD_SET_SRE, 8'h20);
    query(ser_pkg::SER_CMD_GET_STB, 8'h60);
    idle(3);
    chk({7'h00, srq}, 8'h01);
    u_ctrl.pulse('{serial_poll: 1'b1, default: '0});
    answer(8'h60);
    idle(3);
    chk({7'h00, srq}, 8'h00);
    query(ser_pkg::SER_CMD_GET_STB, 8'h60);
    query(ser_pkg::SER_CMD_GET_EER, 8'hC8);
    u_ctrl.send(ser_pkg::SER_CMD_SET_ESE, 8'h00);
    query(ser_pkg::SER_CMD_GET_STB, 8'h00);
    u_ctrl.send(ser_pkg::SER_CMD_SET_ESE, 8'h10);
    u_ctrl.send(ser_pkg::SER_CMD_SET_PRE, 8'h20);
    query(ser_pkg::SER_CMD_GET_PRE, 8'h20);
    chk({7'h00, ist}, 8'h01);
    query(ser_pkg::SER_CMD_GET_IST, 8'h01);
    u_ctrl.send(ser_pkg::SER_CMD_PP_CONFIG, 8'h0A);
    u_ctrl.set_pp(1'b1);
    idle(4);
    chk(dio_oe, 8'h04);
    chk(bus | dio, 8'hFB);
    u_ctrl.send(ser_pkg::SER_CMD_PP_RELEASE, 8'h00);
    idle(4);
    chk(dio_oe, 8'h00);
    u_ctrl.send(ser_pkg::SER_CMD_PP_CONFIG, 8'h02);
    idle(4);
    chk(dio_oe, 8'h00);
    u_ctrl.send(ser_pkg::SER_CMD_PP_RELEASE, 8'h00);
    u_ctrl.set_pp(1'b0);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h10);
    query(ser_pkg::SER_CMD_GET_IST, 8'h00);
    u_ctrl.pulse('{msg_ready: 1'b1, default: '0});
    query(ser_pkg::SER_CMD_GET_STB, 8'h10);
    u_ctrl.pulse('{queue_full: 1'b1, default: '0});
    chk({7'h00, disc}, 8'h01);
    query(ser_pkg::SER_CMD_GET_QER, 8'h02);
    query(ser_pkg::SER_CMD_GET_STB, 8'h00);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h04);
    u_ctrl.pulse('{msg_ready: 1'b1, default: '0});
    u_ctrl.pulse('{term_parsed: 1'b1, default: '0});
    chk({7'h00, disc}, 8'h01);
    query(ser_pkg::SER_CMD_GET_QER, 8'h01);
    u_ctrl.pulse('{msg_ready: 1'b1, default: '0});
    u_ctrl.pulse('{second_end: 1'b1, default: '0});
    query(ser_pkg::SER_CMD_GET_QER, 8'h01);
    u_ctrl.pulse(talk_idle);
    chk({7'h00, prst}, 8'h01);
    query(ser_pkg::SER_CMD_GET_QER, 8'h03);
    u_ctrl.pulse('{msg_ready: 1'b1, default: '0});
    u_ctrl.pulse('{term_sent: 1'b1, default: '0});
    query(ser_pkg::SER_CMD_GET_STB, 8'h00);
    u_ctrl.pulse('{exec_err: 1'b1, exec_code: 8'h67, default: '0});
    u_ctrl.pulse(talk_idle);
    u_ctrl.send(ser_pkg::SER_CMD_CLS, 8'h00);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h00);
    query(ser_pkg::SER_CMD_GET_EER, 8'h00);
    query(ser_pkg::SER_CMD_GET_QER, 8'h00);
    lim = 3'h5;
    query(ser_pkg::SER_CMD_GET_STB, 8'h05);
    lim = 3'h2;
    query(ser_pkg::SER_CMD_GET_STB, 8'h02);
    lim = 3'h0;
    u_ctrl.pulse('{verify_start: 1'b1, default: '0});
    idle(VC + 5);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h08);
    u_ctrl.pulse('{verify_start: 1'b1, default: '0});
    idle(VC / 2);
    u_ctrl.pulse('{verify_done: 1'b1, default: '0});
    idle(VC + 5);
    query(ser_pkg::SER_CMD_GET_ESR, 8'h00);
    rst = 1'b1;
    idle(8);
    rst = 1'b0;
    query(ser_pkg::SER_CMD_GET_ESR, 8'h80);
    query(ser_pkg::SER_CMD_GET_ESE, 8'h00);
    results();
  end
endmodule : tb
